// ---- psa_pkg.sv ----
// Package with register map, reset values and address arithmetic for the subsample sequencer.
package psa_pkg;

  // Register offsets on the configuration port.
  localparam logic [15:0] OFS_GROUPED_UPDATE_HOLD = 16'h0104;
  localparam logic [15:0] OFS_COLUMN_WINDOW_FIRST = 16'h0344;
  localparam logic [15:0] OFS_ROW_WINDOW_FIRST    = 16'h0346;
  localparam logic [15:0] OFS_COLUMN_WINDOW_LAST  = 16'h0348;
  localparam logic [15:0] OFS_ROW_WINDOW_LAST     = 16'h034a;
  localparam logic [15:0] OFS_OUTPUT_WIDTH        = 16'h034c;
  localparam logic [15:0] OFS_OUTPUT_HEIGHT       = 16'h034e;
  localparam logic [15:0] OFS_COLUMN_STEP_CODE    = 16'h0382;
  localparam logic [15:0] OFS_ROW_STEP_CODE       = 16'h0386;
  localparam logic [15:0] OFS_READOUT_COLUMNS     = 16'h3f00;
  localparam logic [15:0] OFS_READOUT_ROWS        = 16'h3f02;
  localparam logic [15:0] OFS_SEQ_STATUS          = 16'h3f04;

  // Values after reset: full resolution window starting at (8,8).
  localparam logic [7:0]  RST_HOLD         = 8'h00;
  localparam logic [15:0] RST_COLUMN_FIRST = 16'h0008;
  localparam logic [15:0] RST_ROW_FIRST    = 16'h0008;
  localparam logic [15:0] RST_COLUMN_LAST  = 16'h0a27;
  localparam logic [15:0] RST_ROW_LAST     = 16'h079f;
  localparam logic [15:0] RST_WIDTH        = 16'h0a20;
  localparam logic [15:0] RST_HEIGHT       = 16'h0798;
  localparam logic [15:0] RST_STEP         = 16'h0001;

  // Accepted step codes.
  localparam logic [15:0] STEP_NORMAL = 16'h0001;
  localparam logic [15:0] STEP_SKIP2  = 16'h0003;
  localparam logic [15:0] STEP_SKIP4  = 16'h0007;

  // Hold field position inside the hold register.
  localparam int HOLD_BIT = 0;

  // Sequencer state machine.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } psa_state_type;

  // True for a step code the sequencer can follow.
  function automatic logic step_ok(input logic [15:0] code);
    step_ok = (code == STEP_NORMAL) || (code == STEP_SKIP2) || (code == STEP_SKIP4);
  endfunction : step_ok

  // Addresses read along one axis: (last - first + step) / skip, skip = (step + 1) / 2.
  function automatic logic [15:0] axis_count(input logic [15:0] first,
                                             input logic [15:0] last,
                                             input logic [15:0] code);
    logic [15:0] span;
    logic [15:0] skip;
    span = last - first + code;
    skip = (code + 16'h0001) >> 1;
    axis_count = (skip == 16'h0004) ? (span >> 2) : (skip == 16'h0002) ? (span >> 1) : span;
  endfunction : axis_count

endpackage : psa_pkg

// ---- psa_axis_if.sv ----
// Interface joining the frame control to one axis address stepper.
`timescale 1ns/10ps
interface psa_axis_if;
  logic        load;
  logic        adv;
  logic [15:0] first;
  logic [15:0] last;
  logic [15:0] step;
  logic [15:0] addr;
  logic [15:0] count;
  logic        done;

  modport ctrl (output load, output adv, output first, output last, output step,
                input addr, input count, input done);
  modport axis (input load, input adv, input first, input last, input step,
                output addr, output count, output done);
endinterface : psa_axis_if

// ---- psa_axis_stepper.sv ----
// Address stepper for one axis: walks pairs of addresses and jumps by the step code.
`timescale 1ns/10ps
module psa_axis_stepper (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control side
  psa_axis_if.axis ax
);

  logic [15:0] addr_r;
  logic [15:0] left_r;
  logic [15:0] addr_nxt;
  logic [15:0] left_nxt;
  logic [15:0] span_count;

  assign span_count = psa_pkg::axis_count(ax.first, ax.last, ax.step);

  // same walk, larger jump
  // An even address is the first of a pair, so it moves by one; an odd one moves
  // by the step code, which skips one pair for code 3 and three pairs for code 7.
  assign addr_nxt = ax.load ? ax.first : (addr_r[0] ? addr_r + ax.step : addr_r + 16'h0001);
  assign left_nxt = ax.load ? span_count : left_r - 16'h0001;

  // Address and remaining count move only on load or advance.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= 16'h0000;
      left_r <= 16'h0000;
    end else if (ax.load || ax.adv) begin
      addr_r <= addr_nxt;
      left_r <= left_nxt;
    end
  end

  assign ax.addr  = addr_r;
  assign ax.count = span_count;
  assign ax.done  = (left_r <= 16'h0001); // Last address of the axis is on show.

endmodule : psa_axis_stepper

// ---- psa_sequencer.sv ----
// Subsampled readout address sequencer with its configuration registers.
// Contract
// - Only step codes 1, 3 and 7 are accepted; writes of other codes are ignored.
// - Column and row step codes are independent, so each axis subsamples on its own.
// - Both codes at 3 read half the rows and half the columns, a quarter-size image.
// - Both codes at 7 read a quarter of each axis, one sixteenth of the image.
// - Each axis skip factor is its step code plus one, halved, giving 1, 2 or 4.
// - Each axis reads (last - first + step) / skip addresses.
// - With code 3 an address pair is read and the next pair skipped.
// - With code 7 an address pair is read and the next six addresses skipped.
`timescale 1ns/10ps
module psa_sequencer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Configuration register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // Readout control
  input  wire logic        stream_en,
  // Address stream
  output logic             pix_valid,
  output logic      [15:0] col_addr,
  output logic      [15:0] row_addr,
  output logic             frame_start,
  output logic             line_start,
  output logic             frame_end
);

  psa_axis_if col_if ();
  psa_axis_if row_if ();

  // Registers as written by software.
  logic [7:0]  hold_r;
  logic [15:0] col_first_r;
  logic [15:0] row_first_r;
  logic [15:0] col_last_r;
  logic [15:0] row_last_r;
  logic [15:0] width_r;
  logic [15:0] height_r;
  logic [15:0] col_step_r;
  logic [15:0] row_step_r;
  // Active copies that steer the walk.
  logic [15:0] act_col_first_r;
  logic [15:0] act_row_first_r;
  logic [15:0] act_col_last_r;
  logic [15:0] act_row_last_r;
  logic [15:0] act_col_step_r;
  logic [15:0] act_row_step_r;
  // Sequencer state and outputs.
  psa_pkg::psa_state_type state_r;
  psa_pkg::psa_state_type state_nxt;
  logic        pix_valid_r;
  logic        frame_start_r;
  logic        line_start_r;
  logic        frame_end_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  // Write decode.
  wire         wr_hold      = reg_wr && (reg_addr == psa_pkg::OFS_GROUPED_UPDATE_HOLD);
  wire         wr_col_first = reg_wr && (reg_addr == psa_pkg::OFS_COLUMN_WINDOW_FIRST);
  wire         wr_row_first = reg_wr && (reg_addr == psa_pkg::OFS_ROW_WINDOW_FIRST);
  wire         wr_col_last  = reg_wr && (reg_addr == psa_pkg::OFS_COLUMN_WINDOW_LAST);
  wire         wr_row_last  = reg_wr && (reg_addr == psa_pkg::OFS_ROW_WINDOW_LAST);
  wire         wr_width     = reg_wr && (reg_addr == psa_pkg::OFS_OUTPUT_WIDTH);
  wire         wr_height    = reg_wr && (reg_addr == psa_pkg::OFS_OUTPUT_HEIGHT);
  wire         wr_col_step  = reg_wr && (reg_addr == psa_pkg::OFS_COLUMN_STEP_CODE)
                              && psa_pkg::step_ok(reg_wdata);
  wire         wr_row_step  = reg_wr && (reg_addr == psa_pkg::OFS_ROW_STEP_CODE)
                              && psa_pkg::step_ok(reg_wdata);
  wire         hold_on      = hold_r[psa_pkg::HOLD_BIT];

  // Software-facing registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_r      <= psa_pkg::RST_HOLD;
      col_first_r <= psa_pkg::RST_COLUMN_FIRST;
      row_first_r <= psa_pkg::RST_ROW_FIRST;
      col_last_r  <= psa_pkg::RST_COLUMN_LAST;
      row_last_r  <= psa_pkg::RST_ROW_LAST;
      width_r     <= psa_pkg::RST_WIDTH;
      height_r    <= psa_pkg::RST_HEIGHT;
      col_step_r  <= psa_pkg::RST_STEP;
      row_step_r  <= psa_pkg::RST_STEP;
    end else begin
      if (wr_hold)      hold_r      <= reg_wdata[7:0];
      if (wr_col_first) col_first_r <= reg_wdata;
      if (wr_row_first) row_first_r <= reg_wdata;
      if (wr_col_last)  col_last_r  <= reg_wdata;
      if (wr_row_last)  row_last_r  <= reg_wdata;
      if (wr_width)     width_r     <= reg_wdata;
      if (wr_height)    height_r    <= reg_wdata;
      if (wr_col_step)  col_step_r  <= reg_wdata;
      if (wr_row_step)  row_step_r  <= reg_wdata;
    end
  end

  // A new frame may only begin when streaming and no grouped update is open.
  wire         frame_go  = (state_r == psa_pkg::ST_IDLE) && stream_en && !hold_on;
  wire         run       = (state_r == psa_pkg::ST_RUN);
  wire         line_end  = run && col_if.done;
  wire         last_pix  = line_end && row_if.done;

  // grouped commit
  // Active settings are copied in each idle cycle with the hold released; a frame that starts in the first cycle
  // after release still loads the old window and count, then steps and reloads lines with the new values.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_col_first_r <= psa_pkg::RST_COLUMN_FIRST;
      act_row_first_r <= psa_pkg::RST_ROW_FIRST;
      act_col_last_r  <= psa_pkg::RST_COLUMN_LAST;
      act_row_last_r  <= psa_pkg::RST_ROW_LAST;
      act_col_step_r  <= psa_pkg::RST_STEP;
      act_row_step_r  <= psa_pkg::RST_STEP;
    end else if (state_r == psa_pkg::ST_IDLE && !hold_on) begin
      act_col_first_r <= col_first_r;
      act_row_first_r <= row_first_r;
      act_col_last_r  <= col_last_r;
      act_row_last_r  <= row_last_r;
      act_col_step_r  <= col_step_r;
      act_row_step_r  <= row_step_r;
    end
  end

  // each axis follows its own step code
  // Column axis restarts each line; row axis starts each frame and moves at line end.
  assign col_if.first = act_col_first_r;
  assign col_if.last  = act_col_last_r;
  assign col_if.step  = act_col_step_r;
  assign col_if.load  = frame_go || (line_end && !row_if.done);
  assign col_if.adv   = run && !col_if.done;
  assign row_if.first = act_row_first_r;
  assign row_if.last  = act_row_last_r;
  assign row_if.step  = act_row_step_r;
  assign row_if.load  = frame_go;
  assign row_if.adv   = line_end && !row_if.done;

  psa_axis_stepper u_col (
    .clock (clock),
    .rst_n (rst_n),
    .ax    (col_if.axis)
  );

  psa_axis_stepper u_row (
    .clock (clock),
    .rst_n (rst_n),
    .ax    (row_if.axis)
  );

  // Next state.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      psa_pkg::ST_IDLE: begin
        if (frame_go) state_nxt = psa_pkg::ST_RUN;
      end
      psa_pkg::ST_RUN: begin
        if (last_pix) state_nxt = psa_pkg::ST_IDLE;
      end
      default: state_nxt = psa_pkg::ST_IDLE;
    endcase
  end

  // State and stream markers; markers line up with the address they describe.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= psa_pkg::ST_IDLE;
      pix_valid_r   <= 1'b0;
      frame_start_r <= 1'b0;
      line_start_r  <= 1'b0;
      frame_end_r   <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      pix_valid_r   <= (state_nxt == psa_pkg::ST_RUN);
      frame_start_r <= frame_go;
      line_start_r  <= frame_go || (line_end && !row_if.done);
      frame_end_r   <= last_pix;
    end
  end

  // Read selection; unknown offsets read as zero.
  always_comb begin
    case (reg_addr)
      psa_pkg::OFS_GROUPED_UPDATE_HOLD: rdata_nxt = {8'h00, hold_r};
      psa_pkg::OFS_COLUMN_WINDOW_FIRST: rdata_nxt = col_first_r;
      psa_pkg::OFS_ROW_WINDOW_FIRST:    rdata_nxt = row_first_r;
      psa_pkg::OFS_COLUMN_WINDOW_LAST:  rdata_nxt = col_last_r;
      psa_pkg::OFS_ROW_WINDOW_LAST:     rdata_nxt = row_last_r;
      psa_pkg::OFS_OUTPUT_WIDTH:        rdata_nxt = width_r;
      psa_pkg::OFS_OUTPUT_HEIGHT:       rdata_nxt = height_r;
      psa_pkg::OFS_COLUMN_STEP_CODE:    rdata_nxt = col_step_r;
      psa_pkg::OFS_ROW_STEP_CODE:       rdata_nxt = row_step_r;
      psa_pkg::OFS_READOUT_COLUMNS:     rdata_nxt = col_if.count;
      psa_pkg::OFS_READOUT_ROWS:        rdata_nxt = row_if.count;
      psa_pkg::OFS_SEQ_STATUS:          rdata_nxt = {15'h0000, run};
      default:                          rdata_nxt = 16'h0000;
    endcase
  end

  // Read data is held until the next read strobe.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rdata_r <= 16'h0000;
    else if (reg_rd) rdata_r <= rdata_nxt;
  end

  assign reg_rdata   = rdata_r;
  assign pix_valid   = pix_valid_r;
  assign col_addr    = col_if.addr;
  assign row_addr    = row_if.addr;
  assign frame_start = frame_start_r;
  assign line_start  = line_start_r;
  assign frame_end   = frame_end_r;

endmodule : psa_sequencer

// ---- psa_seq_monitor.sv ----
// Checker with concurrent assertions on the sequencer's ports.
`timescale 1ns/10ps
module psa_seq_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Address stream
  input wire logic        stream_en,
  input wire logic        pix_valid,
  input wire logic [15:0] col_addr,
  input wire logic [15:0] row_addr,
  input wire logic        frame_start,
  input wire logic        line_start,
  input wire logic        frame_end
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Step readback may only ever show an accepted code.
  AST_STEP_LEGAL:
    assert property (reg_rd && (reg_addr == 16'h0382 || reg_addr == 16'h0386) |=>
      reg_rdata inside {16'h0001, 16'h0003, 16'h0007}) else $error("illegal step readback");
  // A frame opens on a pixel that also opens a line.
  AST_FS_LINE:
    assert property (frame_start |-> line_start && pix_valid) else $error("bad frame start");
  // The end pulse comes exactly one cycle after the last pixel.
  AST_END_FELL:
    assert property ($fell(pix_valid) |-> frame_end) else $error("missing frame end");
  AST_END_ONLY:
    assert property (frame_end |-> $fell(pix_valid)) else $error("stray frame end");
  // At least one idle cycle separates frames.
  AST_FS_GAP:
    assert property (frame_start |-> !$past(pix_valid)) else $error("frames without gap");
  // Even column is followed by its odd partner.
  AST_COL_PAIR:
    assert property (pix_valid && !line_start && !$past(col_addr[0]) |->
      col_addr == $past(col_addr) + 16'h0001) else $error("column pair broken");
  // After an odd column the walk jumps by a legal step.
  AST_COL_JUMP:
    assert property (pix_valid && !line_start && $past(col_addr[0]) |->
      (col_addr - $past(col_addr)) inside {16'h0001, 16'h0003, 16'h0007})
      else $error("bad column jump");
  // The row holds along a line.
  AST_ROW_HOLD:
    assert property (pix_valid && !line_start |-> $stable(row_addr)) else $error("row moved");
  // A new line after an even row reads its odd partner.
  AST_ROW_PAIR:
    assert property (line_start && !frame_start && !$past(row_addr[0]) |->
      row_addr == $past(row_addr) + 16'h0001) else $error("row pair broken");
  // Busy readback follows the stream: the walk runs exactly while pixels are valid.
  AST_BUSY_READ:
    assert property (reg_rd && reg_addr == 16'h3f04 |=>
      reg_rdata == {15'h0000, $past(pix_valid)}) else $error("busy readback wrong");
endmodule : psa_seq_monitor
bind psa_sequencer psa_seq_monitor u_mon (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .stream_en(stream_en), .pix_valid(pix_valid), .col_addr(col_addr), .row_addr(row_addr),
  .frame_start(frame_start), .line_start(line_start), .frame_end(frame_end));

// ---- psa_host_model.sv ----
// Host model that programs the sequencer's configuration registers.
`timescale 1ns/10ps
module psa_host_model (
  // Clock
  input  wire logic        clock,
  // Register port
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  // Idle bus at time zero.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end
  // One access; idle address and data are inverted so stale values never look valid.
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge clock);
    #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask : acc
  // Draws an aligned window and programs it; line length register is left untouched.
  task automatic prog(input logic [15:0] cs, rs, output logic [15:0] cf, cl, rf, rl);
    // column first on a skip group, row first on a pair, span in whole groups
    cf = 16'((cs + 16'h0001) * 2 * ($urandom % 4));
    cl = cf + 16'((cs + 16'h0001) * 2 * (1 + $urandom % 2)) - cs;
    rf = 16'(2 * ($urandom % 8));
    rl = rf + 16'((rs + 16'h0001) * 2 * (1 + $urandom % 2)) - rs;
    acc(1'b1, 16'h0104, 16'h0001);
    acc(1'b1, 16'h0382, cs);
    acc(1'b1, 16'h0386, rs);
    acc(1'b1, 16'h0344, cf);
    acc(1'b1, 16'h0346, rf);
    acc(1'b1, 16'h0348, cl);
    acc(1'b1, 16'h034a, rl);
    acc(1'b1, 16'h0104, 16'h0000);
  endtask : prog
endmodule : psa_host_model

// ---- tb.sv ----
// Self-checking bench for the subsample address sequencer.
`timescale 1ns/10ps
module tb;
  logic        clock, rst_n, stream_en, reg_wr, reg_rd;
  logic        pix_valid, frame_start, line_start, frame_end;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, col_addr, row_addr;
  logic [15:0] cf, cl, rf, rl;
  logic [15:0] cod[3] = '{16'h0001, 16'h0003, 16'h0007};
  int          error_cnt, comparisons;
  // Clock of 5 ns period.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  psa_sequencer u_dut (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .stream_en(stream_en), .pix_valid(pix_valid), .col_addr(col_addr),
    .row_addr(row_addr), .frame_start(frame_start), .line_start(line_start),
    .frame_end(frame_end));
  psa_host_model u_host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // Expected count per axis and next address of the pair walk.
  function automatic logic [15:0] cnt(input logic [15:0] f, l, s);
    return (l - f + s) / ((s + 16'h0001) / 2);
  endfunction : cnt
  function automatic logic [15:0] nxt(input logic [15:0] a, s);
    return a[0] ? a + s : a + 16'h0001;
  endfunction : nxt
  // Compare and count.
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Reads a register and compares it.
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    u_host.acc(1'b0, a, 16'h0000);
    chk(34'(reg_rdata), 34'(exp));
  endtask : rchk
  // Programs a window, runs one frame and compares every address.
  task automatic frame(input logic [15:0] cs, rs);
    logic [15:0] c, r;
    int          n;
    u_host.prog(cs, rs, cf, cl, rf, rl);
    rchk(16'h3f00, cnt(cf, cl, cs));
    rchk(16'h3f02, cnt(rf, rl, rs));
    stream_en = 1'b1;
    n = 0;
    while (pix_valid !== 1'b1 && n < 50) begin
      @(posedge clock);
      #1;
      n++;
    end
    stream_en = 1'b0;
    chk(34'(frame_start), 34'h1);
    // busy read mid-walk
    // Every frame lasts at least sixteen pixels, so this read lands while the walk runs.
    fork
      u_host.acc(1'b0, 16'h3f04, 16'h0000);
    join_none
    r = rf;
    for (int y = 0; y < cnt(rf, rl, rs); y++) begin
      c = cf;
      for (int x = 0; x < cnt(cf, cl, cs); x++) begin
        chk({pix_valid, line_start, col_addr, row_addr}, {1'b1, x == 0, c, r});
        c = nxt(c, cs);
        @(posedge clock);
        #1;
      end
      r = nxt(r, rs);
    end
    chk({pix_valid, frame_end}, 34'h1);
    chk(34'(reg_rdata), 34'h1);
    $display("Test frame %h x %h done", cs, rs);
  endtask : frame
  // Verdict and end of run.
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // Watchdog well beyond the expected run length.
  initial begin
    #300000;
    error_cnt++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    {rst_n, stream_en, error_cnt, comparisons} = '0;
    void'($urandom(58));
    repeat (10) @(posedge clock);
    #1 rst_n = 1'b1;
    rchk(16'h0104, 16'h0000);
    rchk(16'h0344, psa_pkg::RST_COLUMN_FIRST);
    rchk(16'h0346, psa_pkg::RST_ROW_FIRST);
    rchk(16'h034e, psa_pkg::RST_HEIGHT);
    rchk(16'h0382, psa_pkg::RST_STEP);
    rchk(16'h3f04, 16'h0000);
    rchk(16'h0348, psa_pkg::RST_COLUMN_LAST);
    rchk(16'h034a, psa_pkg::RST_ROW_LAST);
    rchk(16'h034c, psa_pkg::RST_WIDTH);
    rchk(16'h0386, psa_pkg::RST_STEP);
    rchk(16'h0200, 16'h0000);
    $display("Test reset values done");
    // refused step codes leave the old value
    for (int i = 0; i < 4; i++) begin
      u_host.acc(1'b1, 16'h0382, 16'h0003);
      u_host.acc(1'b1, 16'h0382, 16'(2 * ($urandom % 8)) + 16'h0009 * 16'(i == 0));
      rchk(16'h0382, 16'h0003);
    end
    $display("Test step refusal done");
    u_host.acc(1'b1, 16'h0104, 16'h0001);
    stream_en = 1'b1;
    repeat (20) begin
      @(posedge clock);
      #1;
      chk(34'(pix_valid), 34'h0);
    end
    stream_en = 1'b0;
    $display("Test hold done");
    for (int i = 0; i < 3; i++) frame(cod[i], cod[i]);
    frame(16'h0003, 16'h0001);
    frame(16'h0001, 16'h0007);
    for (int i = 0; i < 6; i++) frame(cod[$urandom % 3], cod[$urandom % 3]);
    end_of_test();
  end
endmodule : tb
